/* logic/result_logger_map.vh */
// Purpose: Constants for the shared memory result logger.
// Assumes: One 20 MHz clock, synchronous active-low reset.
// Notes: Addresses are byte addresses in the 24-bit shared space.
// Functional notes
// - Shared storage off by default; results kept locally only, no shared writes.
// - Shared storage on: each result after block start and before operation complete goes to next shared address and local memory.
//   Here a result arriving while a shared write still awaits ready goes to local memory only.
// - Shared region spans up to 12 megabytes, open to any backplane instrument.
// - Continuous mode: operation complete set once the sized region is filled.
// - Results stored equal region size in bytes divided by eight, one record each.
// - Continuous mode: pointer wraps to start when the full space is filled.
// - Latest result is still kept locally so a fetch returns it.
// - Minimum resolution calibrates once per block, otherwise before every measurement.
// - After reset the base address holds its default and reads back.
// - In continuous mode, after all results are stored, operation complete reads as one.
`ifndef RESULT_LOGGER_MAP_VH
`define RESULT_LOGGER_MAP_VH
`define RL_ADDR_W 24
`define RL_REC_BYTES 24'h000008
`define RL_REC_SHIFT 3
`define RL_SPACE_BYTES 24'hC00000
`define RL_BASE_RST 24'h200000
`define RL_SIZE_RST 24'h000000
`define RL_LOCAL_DEPTH_LOG2 4
`endif

/* logic/result_store.v */
// Purpose: Small local result memory with registered read data.
// Assumes: Single clock, one write and one read port.
// Notes: Read data appear one cycle after the read address.
`timescale 1ns/1ns
`default_nettype none
module result_store #(
	parameter AW = 4,
	parameter DW = 64
) (
	input wire clk_i,
	input wire we_i,
	input wire [AW-1:0] waddr_i,
	input wire [DW-1:0] wdata_i,
	input wire [AW-1:0] raddr_i,
	output reg [DW-1:0] rdata_o
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule
`default_nettype wire

/* logic/shared_memory_result_logger.v */
// Purpose: Copies measurement results into the shared A24 region and each one into a local store.
// Assumes: Results arrive as one-cycle strobes; backplane writer accepts with a ready.
// Notes: Region base and size are plain configuration ports, no register bus.
`timescale 1ns/1ns
`default_nettype none
`include "result_logger_map.vh"
module shared_memory_result_logger #(
	parameter DW = 64,
	parameter LAW = `RL_LOCAL_DEPTH_LOG2
) (
	input wire CORE_CLK_I,
	input wire RST_N_I,
	input wire SHARED_EN_I,
	input wire CONT_MODE_I,
	input wire MIN_RES_I,
	input wire BASE_WE_I,
	input wire [23:0] BASE_I,
	input wire SIZE_WE_I,
	input wire [23:0] SIZE_I,
	input wire BLOCK_START_I,
	input wire RESULT_VALID_I,
	input wire [DW-1:0] RESULT_I,
	input wire MEM_READY_I,
	input wire FETCH_I,
	input wire [LAW-1:0] FETCH_IDX_I,
	output reg [23:0] BASE_O,
	output reg [23:0] SIZE_O,
	output reg MEM_WR_O,
	output reg [23:0] MEM_ADDR_O,
	output reg [DW-1:0] MEM_DATA_O,
	output reg OPC_O,
	output reg CAL_REQ_O,
	output reg [DW-1:0] LATEST_O,
	output reg [LAW-1:0] LOCAL_COUNT_O,
	output reg [DW-1:0] FETCH_DATA_O,
	output reg FETCH_VALID_O
);
	////////////////////////////////////////////////////////////////////
	localparam ST_IDLE = 2'b00;
	localparam ST_WRITE = 2'b01;

	reg [1:0] state_q, state_d;
	reg [23:0] wptr_q, wptr_d;
	reg [20:0] stored_q, stored_d;
	reg [20:0] limit;
	reg in_block_q;
	reg [LAW-1:0] lwr_q;
	reg fetch_q;
	wire [DW-1:0] store_rdata;
	wire take_shared;
	wire [23:0] next_ptr;
	wire space_end;

	always @* begin
		limit = SIZE_O[23:`RL_REC_SHIFT];
	end
	// Accept a result for shared storage only when enabled and after a block start
	assign take_shared = RESULT_VALID_I && SHARED_EN_I && in_block_q;
	assign next_ptr = wptr_q + `RL_REC_BYTES;
	assign space_end = (next_ptr - BASE_O) >= `RL_SPACE_BYTES;

	////////////////////////////////////////////////////////////////////
	// Configuration: base defaults at reset and reads back
	always @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			BASE_O <= `RL_BASE_RST;
			SIZE_O <= `RL_SIZE_RST;
		end else begin
			if (BASE_WE_I) begin
				BASE_O <= BASE_I;
			end
			if (SIZE_WE_I) begin
				// Clamp to the full space so the region never exceeds it
				SIZE_O <= (SIZE_I > `RL_SPACE_BYTES) ? `RL_SPACE_BYTES : SIZE_I;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Shared-region writer
	always @* begin
		state_d = state_q;
		wptr_d = wptr_q;
		stored_d = stored_q;
		case (state_q)
			ST_IDLE: begin
				if (take_shared && !OPC_O) begin
					state_d = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (MEM_READY_I) begin
					state_d = ST_IDLE;
					stored_d = stored_q + 21'h000001;
					if (CONT_MODE_I && space_end) begin
						wptr_d = BASE_O;
					end else begin
						wptr_d = next_ptr;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// A write in flight still completes: dropping it would break hold-until-ready
		if (BLOCK_START_I) begin
			wptr_d = BASE_O;
			stored_d = 21'h000000;
		end
	end

	always @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			state_q <= ST_IDLE;
			wptr_q <= `RL_BASE_RST;
			stored_q <= 21'h000000;
			in_block_q <= 1'b0;
			MEM_WR_O <= 1'b0;
			MEM_ADDR_O <= 24'h000000;
			MEM_DATA_O <= {DW{1'b0}};
			OPC_O <= 1'b0;
		end else begin
			state_q <= state_d;
			wptr_q <= wptr_d;
			stored_q <= stored_d;
			if (BLOCK_START_I) begin
				in_block_q <= 1'b1;
			end
			if (state_q == ST_IDLE && state_d == ST_WRITE) begin
				MEM_WR_O <= 1'b1;
				MEM_ADDR_O <= wptr_q;
				MEM_DATA_O <= RESULT_I;
			end else if (state_q == ST_WRITE && MEM_READY_I) begin
				MEM_WR_O <= 1'b0;
			end
			if (BLOCK_START_I) begin
				OPC_O <= 1'b0;
			end else if (CONT_MODE_I && limit != 21'h000000 && stored_d >= limit) begin
				OPC_O <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Calibration request: once per block at minimum resolution
	always @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			CAL_REQ_O <= 1'b0;
		end else begin
			if (BLOCK_START_I) begin
				CAL_REQ_O <= 1'b1;
			end else if (RESULT_VALID_I) begin
				// Calibrate ahead of the next measurement unless minimum resolution
				CAL_REQ_O <= !MIN_RES_I;
			end else begin
				CAL_REQ_O <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Local result store, always written
	always @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			lwr_q <= {LAW{1'b0}};
			LOCAL_COUNT_O <= {LAW{1'b0}};
			LATEST_O <= {DW{1'b0}};
			fetch_q <= 1'b0;
			FETCH_VALID_O <= 1'b0;
			FETCH_DATA_O <= {DW{1'b0}};
		end else begin
			fetch_q <= FETCH_I;
			FETCH_VALID_O <= fetch_q;
			if (fetch_q) begin
				FETCH_DATA_O <= store_rdata;
			end
			if (RESULT_VALID_I) begin
				lwr_q <= lwr_q + {{(LAW-1){1'b0}}, 1'b1};
				LOCAL_COUNT_O <= lwr_q;
				LATEST_O <= RESULT_I;
			end
		end
	end

	result_store #(
		.AW(LAW),
		.DW(DW)
	) u_store (
		.clk_i(CORE_CLK_I),
		.we_i(RESULT_VALID_I),
		.waddr_i(lwr_q),
		.wdata_i(RESULT_I),
		.raddr_i(FETCH_IDX_I),
		.rdata_o(store_rdata)
	);
endmodule
`default_nettype wire

/* bench/logger_monitor.sv */
// Purpose: port checker. Assumes: one clock, sync low reset. Notes: 12 MB wrap is not reached.
`timescale 1ns/1ns
`default_nettype none
module logger_monitor (
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic SHARED_EN_I,
	input wire logic MIN_RES_I,
	input wire logic BLOCK_START_I,
	input wire logic RESULT_VALID_I,
	input wire logic MEM_READY_I,
	input wire logic FETCH_I,
	input wire logic [23:0] BASE_O,
	input wire logic MEM_WR_O,
	input wire logic [23:0] MEM_ADDR_O,
	input wire logic OPC_O,
	input wire logic CAL_REQ_O,
	input wire logic FETCH_VALID_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	logic [23:0] nxt_q;
	logic first_q;
	sequence s_acc;
		MEM_WR_O && MEM_READY_I;
	endsequence
	always @(posedge CORE_CLK_I) begin
		if (!RST_N_I || BLOCK_START_I)
			first_q <= RST_N_I;
		else if (MEM_WR_O && MEM_READY_I)
			first_q <= 1'h0;
		if (MEM_WR_O && MEM_READY_I)
			nxt_q <= MEM_ADDR_O + 24'h000008;
	end
	a_local_only: assert property (RESULT_VALID_I && !SHARED_EN_I && !MEM_WR_O |=> !MEM_WR_O)
		else $error("shared write with storage off");
	a_wr_hold: assert property (MEM_WR_O && !MEM_READY_I |=> MEM_WR_O && $stable(MEM_ADDR_O))
		else $error("write dropped before ready");
	a_wr_drop: assert property (s_acc |=> !MEM_WR_O)
		else $error("write held after accept");
	a_first_base: assert property ($rose(MEM_WR_O) && first_q |-> MEM_ADDR_O == BASE_O)
		else $error("block did not start at base");
	a_addr_step: assert property ($rose(MEM_WR_O) && !first_q |-> MEM_ADDR_O == nxt_q)
		else $error("address did not step by eight");
	a_cal_start: assert property (BLOCK_START_I |=> CAL_REQ_O && !OPC_O)
		else $error("block start without calibrate");
	a_cal_each: assert property (RESULT_VALID_I && !MIN_RES_I |=> CAL_REQ_O)
		else $error("no calibrate per result");
	a_cal_once: assert property (RESULT_VALID_I && MIN_RES_I && !BLOCK_START_I |=> !CAL_REQ_O)
		else $error("calibrate at minimum resolution");
	a_fetch_lat: assert property (FETCH_I |-> ##2 FETCH_VALID_O)
		else $error("fetch answer late");
	a_base_rst: assert property ($rose(RST_N_I) |-> BASE_O == 24'h200000)
		else $error("base reset value wrong");
endmodule
`default_nettype wire

/* bench/backplane_mem_model.sv */
// Purpose: shared memory side. Assumes: one write at a time. Notes: fast_i picks prompt or slow.
`timescale 1ns/1ns
`default_nettype none
module backplane_mem_model (
	input wire logic clk_i,
	input wire logic wr_i,
	input wire logic fast_i,
	output logic ready_o
);
	logic [1:0] wait_q = 2'h0;
	// Any write is taken, slow ones after a stall of two cycles
	assign ready_o = wr_i && (fast_i || wait_q[1]);
	always @(posedge clk_i)
		wait_q <= (wr_i && !ready_o) ? wait_q + 2'h1 : 2'h0;
endmodule
`default_nettype wire

/* bench/shared_memory_result_logger_tb_top.sv */
// Purpose: bench for the logger. Assumes: 20 MHz. Notes: scoreboard pops on each accepted write.
`timescale 1ns/1ns
`default_nettype none
module shared_memory_result_logger_tb_top;
	logic clk = 1'h0, rst_n = 1'h0, en = 1'h0, cont = 1'h0, mres = 1'h0, bwe = 1'h0;
	logic swe = 1'h0, bst = 1'h0, rv = 1'h0, fet = 1'h0, fast = 1'h0;
	logic [23:0] base = 24'h0, size = 24'h0, b;
	logic [63:0] res = 64'h0, v;
	logic [3:0] fidx = 4'h0;
	logic [87:0] q[$];
	logic [87:0] e;
	logic [63:0] fq[$];
	wire [23:0] base_o, size_o, addr;
	wire [63:0] data, latest, fdata;
	wire [3:0] cnt;
	wire wr, rdy, opc, cal, fv;
	int miscompares = 0, check_count = 0, k;
	shared_memory_result_logger shared_memory_result_logger_i (.CORE_CLK_I(clk), .RST_N_I(rst_n),
		.SHARED_EN_I(en), .CONT_MODE_I(cont), .MIN_RES_I(mres), .BASE_WE_I(bwe), .BASE_I(base),
		.SIZE_WE_I(swe), .SIZE_I(size), .BLOCK_START_I(bst), .RESULT_VALID_I(rv), .RESULT_I(res),
		.MEM_READY_I(rdy), .FETCH_I(fet), .FETCH_IDX_I(fidx), .BASE_O(base_o), .SIZE_O(size_o),
		.MEM_WR_O(wr), .MEM_ADDR_O(addr), .MEM_DATA_O(data), .OPC_O(opc), .CAL_REQ_O(cal),
		.LATEST_O(latest), .LOCAL_COUNT_O(cnt), .FETCH_DATA_O(fdata), .FETCH_VALID_O(fv));
	backplane_mem_model backplane_mem_model_i (.clk_i(clk), .wr_i(wr), .fast_i(fast), .ready_o(rdy));
	always #25 clk = ~clk;
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task close_out;
		if (miscompares == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One result, then wait out any pending shared write
	task automatic send(input logic push);
		v = {$urandom, $urandom};
		if (push)
			q.push_back({b + {k[20:0], 3'h0}, v});
		@(posedge clk) begin
			rv <= 1'h1;
			res <= v;
			fast <= $urandom;
		end
		@(posedge clk) rv <= 1'h0;
		@(negedge clk);
		for (int i = 0; i < 10 && wr; i++) @(negedge clk);
	endtask
	always @(posedge clk) if (wr === 1'h1 && rdy === 1'h1) begin
		if (q.size() == 0) chk(1, 0);
		else begin
			e = q.pop_front();
			chk(addr, e[87:64]);
			chk(data, e[63:0]);
		end
	end
	always @(posedge clk) if (fv === 1'h1) begin
		if (fq.size() == 0) chk(1, 0);
		else chk(fdata, fq.pop_front());
	end
	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		close_out;
	end
	initial begin
		void'($urandom(32'h18C36C5A));
		b = $urandom & 24'hFFFFF8;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(negedge clk) chk(base_o, 24'h200000);
		@(posedge clk) begin
			bwe <= 1'h1;
			base <= b;
			swe <= 1'h1;
			size <= 24'h000018;
			en <= 1'h1;
			cont <= 1'h1;
			mres <= $urandom;
		end
		@(posedge clk) begin
			bwe <= 1'h0;
			swe <= 1'h0;
			bst <= 1'h1;
		end
		@(posedge clk) bst <= 1'h0;
		@(negedge clk) chk(base_o, b);
		chk(size_o, 24'h000018);
		for (k = 0; k < 4; k++) send(k < 3);
		chk(opc, 1);
		chk(latest, v);
		chk(cnt, 4'h3);
		@(posedge clk) begin
			fet <= 1'h1;
			fidx <= cnt;
			fq.push_back(v);
		end
		@(posedge clk) begin
			fet <= 1'h0;
			en <= 1'h0;
			mres <= ~mres;
			bst <= 1'h1;
			swe <= 1'h1;
			size <= 24'hFFFFF8;
		end
		@(posedge clk) begin
			bst <= 1'h0;
			swe <= 1'h0;
		end
		@(negedge clk) chk(size_o, 24'hC00000);
		chk(opc, 0);
		for (k = 0; k < 2; k++) send(0);
		chk(q.size(), 0);
		chk(fq.size(), 0);
		close_out;
	end
endmodule
bind shared_memory_result_logger logger_monitor logger_monitor_i (.*);
`default_nettype wire
